//--- pkg/periodic_timer_pkg.sv
// Constants, register map and types shared by the periodic interrupt timer.
//
// Functional notes
// RULE1: Raise interrupt requests repeatedly at programmed interval and priority, prescaler on system clock.
// RULE2: Control register holds a three-bit request level and an eight-bit vector.
// RULE3: Control bits ten down to zero are readable and writable at any time.
// RULE4: Control bits fifteen to eleven ignore writes and read as zero.
// RULE5: Level 000 disables the request; 001 to 110 assert levels one to six.
// RULE6: Timer request wins over an external request of equal level.
// RULE7: Timer keeps counting while the request level disables the interrupt.
// RULE8: Level 111 asserts request level seven, the highest priority.
// RULE9: On acknowledge the programmed eight-bit vector is driven out as the vector.
// RULE10: A timing modulus of zero stops the periodic timer.
// RULE11: Prescale select set divides the timer clock by 512, clear leaves it undivided.
// RULE12: On expiry reload modulus, restart, and hold the request until acknowledged.
`default_nettype none

package periodic_timer_pkg;

	// ==========================================================
	// Register byte addresses on the Avalon-MM slave.
	localparam logic [4:0]  OFS_CONTROL      = 5'h00;
	localparam logic [4:0]  OFS_MODULUS      = 5'h04;
	localparam logic [4:0]  OFS_COUNT        = 5'h08;
	localparam logic [4:0]  OFS_EVT_STATUS   = 5'h0c;
	localparam logic [4:0]  OFS_EVT_CLEAR    = 5'h10;
	localparam logic [4:0]  OFS_EVT_ENABLE   = 5'h14;

	// ==========================================================
	// Control register layout and reset value.
	localparam logic [15:0] CONTROL_RESET    = 16'h000f;
	localparam logic [15:0] CONTROL_WR_MASK  = 16'h07ff;
	localparam int          LEVEL_LSB        = 8;
	localparam int          LEVEL_W          = 3;
	localparam int          VECTOR_LSB       = 0;
	localparam int          VECTOR_W         = 8;
	localparam logic [2:0]  LEVEL_OFF        = 3'h0;

	// ==========================================================
	// Modulus register layout and reset value.
	localparam logic [15:0] MODULUS_RESET    = 16'h0000;
	localparam logic [15:0] MODULUS_WR_MASK  = 16'h01ff;
	localparam int          PRESCALE_BIT     = 8;
	localparam int          MODULUS_LSB      = 0;
	localparam int          MODULUS_W        = 8;

	// ==========================================================
	// Timing counts in core_clk cycles.
	localparam int          BASE_DIV         = 4;
	localparam int          PRESCALE_DIV     = 512;
	localparam int          DIV_CNT_W        = 12;
	localparam logic [1:0]  STRAP_SETTLE     = 2'h3;

	// ==========================================================
	// Event status bits.
	localparam int          EVT_W            = 3;
	localparam int          EVT_EXPIRE       = 0;
	localparam int          EVT_ACK          = 1;
	localparam int          EVT_OVERRUN      = 2;
	localparam logic [2:0]  EVT_RESET        = 3'h0;

	// ==========================================================
	// Timer state.
	typedef enum logic {
		TIMER_STOPPED = 1'b0,
		TIMER_RUNNING = 1'b1
	} timer_state_t;

endpackage

`default_nettype wire

//--- src/periodic_interrupt_timer.sv
// Periodic interrupt timer with an Avalon-MM register slave and vectored acknowledge.
`default_nettype none

module periodic_interrupt_timer #(
	parameter int BASE_DIV     = periodic_timer_pkg::BASE_DIV,
	parameter int PRESCALE_DIV = periodic_timer_pkg::PRESCALE_DIV
) (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        clock_mode_strap,
	input  wire logic        iack_valid,
	input  wire logic [2:0]  iack_level,
	output logic      [2:0]  periodic_request_level,
	output logic             periodic_claim,
	output logic      [7:0]  vector_data,
	output logic             vector_valid,
	output logic             irq
);

	// ==========================================================
	// Helpers.

	// Byte-lane merge used by both writable 16-bit registers; masked bits keep reading zero.
	function automatic logic [15:0] merge16(
		input logic [15:0] old_val,
		input logic [31:0] wdata,
		input logic [3:0]  be,
		input logic [15:0] wmask
	);
		logic [15:0] merged;
		merged = old_val;
		if (be[0]) begin
			merged[7:0] = wdata[7:0];
		end
		if (be[1]) begin
			merged[15:8] = wdata[15:8];
		end
		merge16 = merged & wmask;
	endfunction

	// ==========================================================
	// Declarations.
	logic                                  ack_q;
	logic [31:0]                           readdata_q;
	logic [15:0]                           control_q;
	logic [15:0]                           control_d;
	logic [15:0]                           modulus_q;
	logic [15:0]                           modulus_d;
	logic                                  strap_meta_q;
	logic                                  strap_sync_q;
	logic [1:0]                            strap_cnt_q;
	logic                                  strap_done_q;
	periodic_timer_pkg::timer_state_t      state_q;
	periodic_timer_pkg::timer_state_t      state_d;
	logic [periodic_timer_pkg::MODULUS_W-1:0] count_q;
	logic [periodic_timer_pkg::MODULUS_W-1:0] count_d;
	logic [periodic_timer_pkg::DIV_CNT_W-1:0] div_q;
	logic [periodic_timer_pkg::DIV_CNT_W-1:0] div_d;
	logic                                  expire;
	logic                                  pending_q;
	logic                                  pending_d;
	logic [7:0]                            vector_q;
	logic                                  vector_valid_q;
	logic [periodic_timer_pkg::EVT_W-1:0]  evt_status_q;
	logic [periodic_timer_pkg::EVT_W-1:0]  evt_enable_q;

	// ==========================================================
	// Address decode and bus strobes.
	wire        sel_control  = (avs_address == periodic_timer_pkg::OFS_CONTROL);
	wire        sel_modulus  = (avs_address == periodic_timer_pkg::OFS_MODULUS);
	wire        sel_count    = (avs_address == periodic_timer_pkg::OFS_COUNT);
	wire        sel_status   = (avs_address == periodic_timer_pkg::OFS_EVT_STATUS);
	wire        sel_clear    = (avs_address == periodic_timer_pkg::OFS_EVT_CLEAR);
	wire        sel_enable   = (avs_address == periodic_timer_pkg::OFS_EVT_ENABLE);
	wire        wr_commit    = avs_write & ack_q;
	wire        rd_capture   = avs_read & ~ack_q;

	// One wait cycle per access while enabled; a frozen slave holds waitrequest so no write is lost.
	assign avs_waitrequest = (avs_read | avs_write) & ~(ack_q & clk_en);

	// ==========================================================
	// Field views of the control and modulus registers.
	wire [2:0]  level_field   = control_q[periodic_timer_pkg::LEVEL_LSB +: periodic_timer_pkg::LEVEL_W];   // RULE2
	wire [7:0]  vector_field  = control_q[periodic_timer_pkg::VECTOR_LSB +: periodic_timer_pkg::VECTOR_W]; // RULE2
	wire [7:0]  modulus_field = modulus_q[periodic_timer_pkg::MODULUS_LSB +: periodic_timer_pkg::MODULUS_W];
	wire        prescale_sel  = modulus_q[periodic_timer_pkg::PRESCALE_BIT];
	wire        level_on      = (level_field != periodic_timer_pkg::LEVEL_OFF); // RULE5
	wire        modulus_zero  = (modulus_field == 8'h00);

	// ==========================================================
	// Register writes. Writable bits may change at any time, even mid-count.
	assign control_d = merge16(control_q, avs_writedata, avs_byteenable,
		periodic_timer_pkg::CONTROL_WR_MASK); // RULE3 RULE4

	// Prescale select follows the inverted strap until it settles or software writes it.
	always_comb begin
		modulus_d = modulus_q;
		if (wr_commit && sel_modulus) begin
			modulus_d = merge16(modulus_q, avs_writedata, avs_byteenable,
				periodic_timer_pkg::MODULUS_WR_MASK);
		end else if (!strap_done_q) begin
			modulus_d[periodic_timer_pkg::PRESCALE_BIT] = ~strap_sync_q;
		end
	end

	// Control, modulus and bus acknowledge registers.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			control_q  <= periodic_timer_pkg::CONTROL_RESET;
			modulus_q  <= periodic_timer_pkg::MODULUS_RESET;
			ack_q      <= 1'b0;
		end else if (clk_en) begin
			ack_q     <= (avs_read | avs_write) & ~ack_q;
			modulus_q <= modulus_d;
			if (wr_commit && sel_control) begin
				control_q <= control_d; // RULE3
			end
		end
	end

	// ==========================================================
	// Clock-mode strap capture. The pin is asynchronous, so it is synchronised first and
	// only the second stage is read; the prescale bit is fixed once the count settles.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_meta_q <= 1'b0;
			strap_sync_q <= 1'b0;
			strap_cnt_q  <= 2'h0;
			strap_done_q <= 1'b0;
		end else if (clk_en) begin
			strap_meta_q <= clock_mode_strap;
			strap_sync_q <= strap_meta_q;
			if (!strap_done_q) begin
				strap_cnt_q  <= strap_cnt_q + 2'h1;
				strap_done_q <= (strap_cnt_q == periodic_timer_pkg::STRAP_SETTLE) |
					(wr_commit & sel_modulus);
			end
		end
	end

	// ==========================================================
	// Prescaler. A tick every BASE_DIV or BASE_DIV*512 cycles; >= ends a long count at once on a switch.
	localparam logic [periodic_timer_pkg::DIV_CNT_W-1:0] DIV_FAST =
		periodic_timer_pkg::DIV_CNT_W'(BASE_DIV - 1);
	localparam logic [periodic_timer_pkg::DIV_CNT_W-1:0] DIV_SLOW =
		periodic_timer_pkg::DIV_CNT_W'(BASE_DIV * PRESCALE_DIV - 1);

	wire [periodic_timer_pkg::DIV_CNT_W-1:0] div_limit = prescale_sel ? DIV_SLOW : DIV_FAST; // RULE11
	wire tick = (div_q >= div_limit); // RULE1

	// ==========================================================
	// Timer state machine. Counting does not depend on the level field, so a disabled
	// interrupt still sees the period run; only the request is withheld.
	always_comb begin
		state_d = state_q;
		count_d = count_q;
		div_d   = div_q;
		expire  = 1'b0;
		case (state_q)
			periodic_timer_pkg::TIMER_STOPPED: begin
				div_d = '0;
				if (!modulus_zero) begin
					state_d = periodic_timer_pkg::TIMER_RUNNING;
					count_d = modulus_field;
				end
			end
			periodic_timer_pkg::TIMER_RUNNING: begin
				if (modulus_zero) begin
					state_d = periodic_timer_pkg::TIMER_STOPPED; // RULE10
					count_d = 8'h00;
					div_d   = '0;
				end else if (tick) begin
					div_d = '0;
					if (count_q <= 8'h01) begin
						expire  = 1'b1;            // RULE7
						count_d = modulus_field;   // RULE12
					end else begin
						count_d = count_q - 8'h01;
					end
				end else begin
					div_d = div_q + 1'b1;
				end
			end
			default: begin
				state_d = periodic_timer_pkg::TIMER_STOPPED;
				count_d = 8'h00;
				div_d   = '0;
			end
		endcase
	end

	// Timer state registers.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= periodic_timer_pkg::TIMER_STOPPED;
			count_q <= 8'h00;
			div_q   <= '0;
		end else if (clk_en) begin
			state_q <= state_d;
			count_q <= count_d;
			div_q   <= div_d;
		end
	end

	// ==========================================================
	// Request and acknowledge. The processor acknowledges with its level; a match
	// claims the cycle so the external source at the same level defers to us.
	wire ack_hit = iack_valid & pending_q & level_on & (iack_level == level_field);
	wire overrun = expire & pending_q & ~ack_hit;

	assign periodic_claim = ack_hit; // RULE6

	// A new expiry in the acknowledge cycle re-arms the request: set beats clear.
	assign pending_d = (expire & level_on) | (pending_q & ~ack_hit); // RULE12

	// Levels 1 through 7 pass straight through; 000 asserts nothing.
	assign periodic_request_level = (pending_q && level_on) ? level_field : periodic_timer_pkg::LEVEL_OFF; // RULE5 RULE8

	// Request and vector registers.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pending_q      <= 1'b0;
			vector_q       <= 8'h00;
			vector_valid_q <= 1'b0;
		end else if (clk_en) begin
			pending_q      <= pending_d;
			vector_valid_q <= ack_hit;
			if (ack_hit) begin
				vector_q <= vector_field; // RULE9
			end
		end
	end

	assign vector_data  = vector_q;
	assign vector_valid = vector_valid_q;

	// ==========================================================
	// Event status, clear and enable. A clear never hides an event of the same cycle.
	wire [periodic_timer_pkg::EVT_W-1:0] evt_set = {overrun, ack_hit, expire};
	wire [periodic_timer_pkg::EVT_W-1:0] evt_clr =
		(wr_commit && sel_clear && avs_byteenable[0]) ? avs_writedata[periodic_timer_pkg::EVT_W-1:0] : '0;

	// Sticky event bits and their enables.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			evt_status_q <= periodic_timer_pkg::EVT_RESET;
			evt_enable_q <= periodic_timer_pkg::EVT_RESET;
		end else if (clk_en) begin
			evt_status_q <= (evt_status_q & ~evt_clr) | evt_set;
			if (wr_commit && sel_enable && avs_byteenable[0]) begin
				evt_enable_q <= avs_writedata[periodic_timer_pkg::EVT_W-1:0];
			end
		end
	end

	assign irq = |(evt_status_q & evt_enable_q);

	// ==========================================================
	// Read data. Captured on the first cycle of a read so it stands at the release edge;
	// unmapped and write-only addresses return zero.
	wire [31:0] rd_mux =
		sel_control ? {16'h0000, control_q} :  // RULE4
		sel_modulus ? {16'h0000, modulus_q} :
		sel_count   ? {23'h000000, state_q, count_q} :
		sel_status  ? {29'h00000000, evt_status_q} :
		sel_enable  ? {29'h00000000, evt_enable_q} :
		32'h00000000;

	// Read data register.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			readdata_q <= 32'h00000000;
		end else if (clk_en && rd_capture) begin
			readdata_q <= rd_mux;
		end
	end

	assign avs_readdata = readdata_q;

endmodule

`default_nettype wire

//--- tb/periodic_timer_assertions.sv
// Port-level checker for the periodic interrupt timer.
`default_nettype none

module periodic_timer_checker (
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic        clk_en,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        iack_valid,
	input wire logic [2:0]  iack_level,
	input wire logic [2:0]  periodic_request_level,
	input wire logic        periodic_claim,
	input wire logic [7:0]  vector_data,
	input wire logic        vector_valid
);
	// ==========================================================
	// Clocking and helpers.
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// A read finishes at the edge where waitrequest is sampled low.
	wire logic rd_done = avs_read && !avs_waitrequest;
	wire logic wr_done = avs_write && !avs_waitrequest;

	sequence s_claim;
		periodic_claim;
	endsequence
	sequence s_vec;
		##1 vector_valid;
	endsequence

	// ==========================================================
	// Assertions.
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest)
		else $error("bus request waited more than one cycle");
	a_idle_ready: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest high with no request");
	a_ctrl_upper: assert property (rd_done && avs_address == 5'h00 |-> avs_readdata[31:11] == 21'h0)
		else $error("control upper bits not zero");
	a_mod_upper: assert property (rd_done && avs_address == 5'h04 |-> avs_readdata[31:9] == 23'h0)
		else $error("modulus upper bits not zero");
	a_unmapped_zero: assert property (rd_done && avs_address > 5'h14 |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_claim_match: assert property (s_claim |-> iack_valid && iack_level == periodic_request_level
		&& periodic_request_level != 3'h0)
		else $error("claim without matching acknowledge");
	a_vector_follows: assert property (s_claim |-> s_vec)
		else $error("no vector after claim");
	a_vector_cause: assert property (vector_valid |-> $past(periodic_claim))
		else $error("vector without claim");
	a_vector_holds: assert property (!vector_valid |-> $stable(vector_data))
		else $error("vector changed without acknowledge");
	a_level_holds: assert property (periodic_request_level != 3'h0 && !periodic_claim && !wr_done
		|=> periodic_request_level == $past(periodic_request_level))
		else $error("request dropped without acknowledge");
endmodule

bind periodic_interrupt_timer periodic_timer_checker periodic_timer_checker_i (.core_clk, .reset_n, .clk_en,
	.avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .iack_valid, .iack_level,
	.periodic_request_level, .periodic_claim, .vector_data, .vector_valid);

`default_nettype wire

//--- tb/irq_ack_model.sv
// Behavioural processor side that acknowledges the timer's request after a delay.
`default_nettype none

module irq_ack_model (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic [2:0] request_level,
	input  wire logic [3:0] ack_delay,
	output logic            iack_valid,
	output logic      [2:0] iack_level,
	output logic      [2:0] seen_level
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait_q;

	// ==========================================================
	// One-cycle acknowledge at the requested level once the delay runs out.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			iack_valid <= 1'b0;
			iack_level <= 3'h0;
			seen_level <= 3'h0;
			wait_q     <= 4'h0;
		end else if (iack_valid) begin
			iack_valid <= 1'b0;
			iack_level <= ~iack_level; // Released lines must not look valid.
		end else if (request_level != 3'h0) begin
			if (wait_q == ack_delay) begin
				iack_valid <= 1'b1;
				iack_level <= request_level;
				seen_level <= request_level;
				wait_q     <= 4'h0;
			end else begin
				wait_q <= wait_q + 4'h1;
			end
		end
	end
endmodule

`default_nettype wire

//--- tb/tb_periodic_interrupt_timer.sv
// Self-checking bench for the periodic interrupt timer.
`default_nettype none

`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin n_fail++; \
	$display("MISMATCH %s expected %h seen %h", what, exp, got); end end

module tb_periodic_interrupt_timer;
	timeunit 1ns;
	timeprecision 1ns;
	// Short divisors keep the run brief; expectations use the same values.
	localparam int BDIV = 2;
	localparam int PDIV = 4;
	logic        core_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  ack_delay = 4'h0;
	logic        strap = 1'b0;
	logic [31:0] avs_readdata, rd;
	logic        avs_waitrequest, periodic_claim, vector_valid, irq, iack_valid;
	logic [2:0]  periodic_request_level, iack_level, seen_level;
	logic [7:0]  vector_data;
	int          n_fail = 0, checked = 0, cycles = 0, per;

	always #25 core_clk = ~core_clk;

	periodic_interrupt_timer #(.BASE_DIV(BDIV), .PRESCALE_DIV(PDIV)) periodic_interrupt_timer_i (.core_clk,
		.reset_n, .clk_en(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'h3),
		.avs_readdata, .avs_waitrequest, .clock_mode_strap(strap), .iack_valid, .iack_level,
		.periodic_request_level, .periodic_claim, .vector_data, .vector_valid, .irq);

	irq_ack_model irq_ack_model_i (.clk(core_clk), .reset_n, .request_level(periodic_request_level),
		.ack_delay, .iack_valid, .iack_level, .seen_level);

	// ==========================================================
	// Bus tasks: hold the request until waitrequest is sampled low.
	task automatic bus_write(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= {16'h0, d};
		avs_write <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask

	task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask

	// Cycles from one rise of the request to the next.
	task automatic measure(output int n);
		do @(posedge core_clk); while (periodic_request_level === 3'h0);
		n = 0;
		do begin @(posedge core_clk); n++; end while (periodic_request_level !== 3'h0);
		do begin @(posedge core_clk); n++; end while (periodic_request_level === 3'h0);
	endtask

	task finish_test;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// A hang counts as a mismatch and ends in the closing report.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			finish_test();
		end
	end

	// ==========================================================
	// Main sequence.
	initial begin
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (6) @(posedge core_clk);
		bus_read(periodic_timer_pkg::OFS_CONTROL, rd);
		`CHK("control reset", 32'h0000000f, rd)
		bus_read(periodic_timer_pkg::OFS_MODULUS, rd);
		`CHK("prescale from strap", 32'h00000100, rd)
		bus_write(periodic_timer_pkg::OFS_CONTROL, 16'hffff);
		bus_read(periodic_timer_pkg::OFS_CONTROL, rd);
		`CHK("control mask", 32'h000007ff, rd)
		bus_read(5'h1c, rd);
		`CHK("unmapped read", 32'h0, rd)
		bus_write(periodic_timer_pkg::OFS_CONTROL, 16'h0155);
		bus_write(periodic_timer_pkg::OFS_MODULUS, 16'h0005);
		measure(per);
		`CHK("period plain", 5 * BDIV, per)
		bus_write(periodic_timer_pkg::OFS_MODULUS, 16'h0105);
		measure(per);
		`CHK("period prescaled", 5 * BDIV * PDIV, per)
		// A slow processor; the first vector after a write may still be the old one.
		ack_delay <= 4'h3;
		for (int l = 1; l < 8; l++) begin
			bus_write(periodic_timer_pkg::OFS_CONTROL, {5'h0, l[2:0], 8'h40 + 8'(l)});
			bus_read(periodic_timer_pkg::OFS_CONTROL, rd);
			`CHK("control while running", {21'h0, l[2:0], 8'h40 + 8'(l)}, rd)
			repeat (2) do @(posedge core_clk); while (vector_valid !== 1'b1);
			`CHK("vector", 8'h40 + 8'(l), vector_data)
			`CHK("level", l[2:0], seen_level)
		end
		bus_write(periodic_timer_pkg::OFS_CONTROL, 16'h0000);
		bus_write(periodic_timer_pkg::OFS_EVT_CLEAR, 16'h0007);
		repeat (100) @(posedge core_clk);
		`CHK("disabled level", 3'h0, periodic_request_level)
		bus_read(periodic_timer_pkg::OFS_EVT_STATUS, rd);
		`CHK("expiry while disabled", 1'b1, rd[0])
		bus_read(periodic_timer_pkg::OFS_COUNT, rd);
		`CHK("running while disabled", 1'b1, rd[8])
		bus_write(periodic_timer_pkg::OFS_EVT_ENABLE, 16'h0001);
		@(posedge core_clk);
		`CHK("irq enabled", 1'b1, irq)
		bus_write(periodic_timer_pkg::OFS_EVT_ENABLE, 16'h0000);
		@(posedge core_clk);
		`CHK("irq masked", 1'b0, irq)
		bus_write(periodic_timer_pkg::OFS_MODULUS, 16'h0000);
		repeat (4) @(posedge core_clk);
		bus_write(periodic_timer_pkg::OFS_EVT_CLEAR, 16'h0007);
		bus_read(periodic_timer_pkg::OFS_COUNT, rd);
		`CHK("stopped count", 32'h0, rd)
		repeat (50) @(posedge core_clk);
		bus_read(periodic_timer_pkg::OFS_EVT_STATUS, rd);
		`CHK("no expiry when stopped", 32'h0, rd)
		// Second reset with the strap high: the prescale bit must come up clear.
		strap <= 1'b1;
		reset_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (6) @(posedge core_clk);
		bus_read(periodic_timer_pkg::OFS_MODULUS, rd);
		`CHK("prescale from high strap", 32'h00000000, rd)
		finish_test();
	end
endmodule

`default_nettype wire
